/* File: include/far_pkg.sv */
// constants for the fault auto-restart sequencer
package far_pkg;

	// ==========================================================
	// timing
	localparam int unsigned FAR_CLK_PERIOD_NS = 10;
	localparam int unsigned FAR_TICK_NS = 100_000_000;
	localparam int unsigned FAR_TICK_CYCLES = FAR_TICK_NS / FAR_CLK_PERIOD_NS;
	localparam int unsigned FAR_GOOD_RUN_MIN = 10;
	localparam int unsigned FAR_TICKS_PER_S = 1_000_000_000 / FAR_TICK_NS;
	localparam logic [12:0] FAR_GOOD_RUN_TICKS = 13'(FAR_GOOD_RUN_MIN * 60 * FAR_TICKS_PER_S);

	// ==========================================================
	// settings, interval in tenths of a second
	localparam logic [12:0] FAR_INTERVAL_MIN = 13'h0005;
	localparam logic [12:0] FAR_INTERVAL_MAX = 13'h1770;
	localparam logic [12:0] FAR_INTERVAL_DEF = 13'h0064;
	localparam logic [3:0] FAR_LIMIT_MAX = 4'ha;
	localparam logic [3:0] FAR_LIMIT_DEF = 4'h0;
	localparam logic FAR_FOSEL_DEF = 1'b0;
	localparam logic [7:0] FAR_MO_FAULT = 8'h0b;
	localparam logic [7:0] FAR_MO_RESTART = 8'h0e;
	localparam logic [31:0] FAR_MOFUNC_DEF = 32'h0000_0000;
	localparam int unsigned FAR_NUM_MO = 4;
	localparam int unsigned FAR_MO_W = 8;

	// ==========================================================
	// register map, byte offsets
	localparam logic [7:0] FAR_REG_CTRL = 8'h00;
	localparam logic [7:0] FAR_REG_INTERVAL = 8'h04;
	localparam logic [7:0] FAR_REG_MOFUNC = 8'h08;
	localparam logic [7:0] FAR_REG_STATUS = 8'h0c;
	localparam logic [7:0] FAR_REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] FAR_REG_IRQ_MASK = 8'h14;

	// ctrl fields
	localparam int unsigned FAR_CTRL_LIMIT_LSB = 0;
	localparam int unsigned FAR_CTRL_FOSEL_BIT = 8;
	// status fields
	localparam int unsigned FAR_ST_COUNT_LSB = 0;
	localparam int unsigned FAR_ST_STATE_LSB = 8;
	localparam int unsigned FAR_ST_LOCK_BIT = 16;
	localparam int unsigned FAR_ST_ACTIVE_BIT = 17;
	// interrupt bits
	localparam int unsigned FAR_IRQ_W = 3;
	localparam int unsigned FAR_IRQ_ATTEMPT = 0;
	localparam int unsigned FAR_IRQ_LOCKOUT = 1;
	localparam int unsigned FAR_IRQ_GOODRUN = 2;
	localparam logic [2:0] FAR_IRQ_MASK_DEF = 3'h0;

	typedef enum logic [2:0] {
		FAR_IDLE,
		FAR_WITHDRAW,
		FAR_DIAG,
		FAR_WAIT_INT,
		FAR_RESTART,
		FAR_LOCKOUT
	} far_state_e;

endpackage

/* File: logic/far_tick_gen.sv */
// tenth-of-a-second tick generator
`timescale 1ns/1ps
`default_nettype none
module far_tick_gen
	import far_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = FAR_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	output logic tick
);
	localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] cnt_q;

	// ==========================================================
	// prescaler
	always_ff @(posedge clk) begin
		if (rst || restart || cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	assign tick = (cnt_q == LAST) && !restart;
endmodule
`default_nettype wire

/* File: logic/far_sequencer.sv */
// fault auto-restart sequencer with wishbone registers
// Functional notes
// - only ground, overvoltage, overcurrent, overheat, overload, phase-loss trips restart; the code also restarts on both load-detect trips.
// - restartable fault during run triggers self-diagnosis, then restart with speed search.
// - run command is withdrawn when the output is shut off by a fault.
// - withdraw run, then diagnose, then clear fault, then restart, in order.
// - attempt limit 0 to 10, default 0; stop once attempts reach it.
// - attempt count clears after ten minutes of fault-free run after restart.
// - attempt count clears on manual fault reset.
// - attempt count clears at power-up.
// - fault output select 0 or 1, default 0, gates fault output during restart.
// - interval between attempts 0.5 to 600.0 s, default 10.0 s.
// - output terminal with function code 14 shows restart indication.
// - output terminal with function code 11 shows general fault indication.
`timescale 1ns/1ps
`default_nettype none
module far_sequencer
	import far_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = FAR_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ground_fault_trip,
	input wire logic overvoltage_accel_trip,
	input wire logic overvoltage_decel_trip,
	input wire logic overvoltage_const_trip,
	input wire logic overcurrent_accel_trip,
	input wire logic overcurrent_decel_trip,
	input wire logic overcurrent_const_trip,
	input wire logic heatsink_overheat_trip,
	input wire logic motor_overload_trip,
	input wire logic drive_overload_trip,
	input wire logic load_detect_one_trip,
	input wire logic load_detect_two_trip,
	input wire logic input_phase_loss_trip,
	input wire logic output_phase_loss_trip,
	input wire logic other_fault_trip,
	input wire logic output_shutoff,
	input wire logic run_cmd_fwd,
	input wire logic run_cmd_rev,
	input wire logic diag_done,
	input wire logic diag_pass,
	input wire logic manual_fault_reset,
	output logic run_fwd_out,
	output logic run_rev_out,
	output logic diag_req,
	output logic fault_clear_req,
	output logic speed_search_req,
	output logic restart_stopped,
	output logic multi_out_0,
	output logic multi_out_1,
	output logic multi_out_2,
	output logic multi_out_3,
	output logic irq
);
	far_state_e state_q;
	logic [3:0] limit_q;
	logic fosel_q;
	logic [12:0] interval_q;
	logic [31:0] mofunc_q;
	logic [3:0] count_q;
	logic [12:0] int_cnt_q;
	logic [12:0] good_cnt_q;
	logic good_arm_q;
	logic [FAR_IRQ_W-1:0] irq_stat_q;
	logic [FAR_IRQ_W-1:0] irq_mask_q;
	logic [FAR_IRQ_W-1:0] irq_evt;
	logic [FAR_NUM_MO-1:0] mo_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic acc;
	logic wr;
	logic rd;
	logic restartable;
	logic running;
	logic fault_evt;
	logic tick;
	logic [31:0] wval, ival;
	logic [31:0] status_val;
	logic [12:0] int_new;
	logic [3:0] lim_new;

	// ==========================================================
	// wishbone slave
	assign acc = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = acc && wb_we_i;
	assign rd = acc && !wb_we_i;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	assign status_val = {14'h0000, (state_q != FAR_IDLE && state_q != FAR_LOCKOUT),
		(state_q == FAR_LOCKOUT), 5'h00, 3'(state_q), 4'h0, count_q};

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd) begin
			unique case (wb_adr_i)
				FAR_REG_CTRL: rdata_q <= {23'h000000, fosel_q, 4'h0, limit_q};
				FAR_REG_INTERVAL: rdata_q <= {19'h00000, interval_q};
				FAR_REG_MOFUNC: rdata_q <= mofunc_q;
				FAR_REG_STATUS: rdata_q <= status_val;
				FAR_REG_IRQ_STAT: rdata_q <= {29'h00000000, irq_stat_q};
				FAR_REG_IRQ_MASK: rdata_q <= {29'h00000000, irq_mask_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// settings
	always_comb begin
		wval = merge({23'h000000, fosel_q, 4'h0, limit_q}, wb_dat_i, wb_sel_i);
		lim_new = wval[FAR_CTRL_LIMIT_LSB +: 4];
		if (lim_new > FAR_LIMIT_MAX) begin
			lim_new = FAR_LIMIT_MAX;
		end
		ival = merge({19'h00000, interval_q}, wb_dat_i, wb_sel_i);
		int_new = (ival > 32'(FAR_INTERVAL_MAX)) ? FAR_INTERVAL_MAX : ival[12:0];
		if (int_new < FAR_INTERVAL_MIN) begin
			int_new = FAR_INTERVAL_MIN;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			limit_q <= FAR_LIMIT_DEF;
			fosel_q <= FAR_FOSEL_DEF;
			interval_q <= FAR_INTERVAL_DEF;
			mofunc_q <= FAR_MOFUNC_DEF;
			irq_mask_q <= FAR_IRQ_MASK_DEF;
		end else if (wr) begin
			if (wb_adr_i == FAR_REG_CTRL) begin
				limit_q <= lim_new;
				fosel_q <= wval[FAR_CTRL_FOSEL_BIT];
			end
			if (wb_adr_i == FAR_REG_INTERVAL) begin
				interval_q <= int_new;
			end
			if (wb_adr_i == FAR_REG_MOFUNC) begin
				mofunc_q <= merge(mofunc_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == FAR_REG_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[FAR_IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// fault classification
	assign restartable = ground_fault_trip || overvoltage_accel_trip
		|| overvoltage_decel_trip || overvoltage_const_trip || overcurrent_accel_trip
		|| overcurrent_decel_trip || overcurrent_const_trip || heatsink_overheat_trip
		|| motor_overload_trip || drive_overload_trip || load_detect_one_trip
		|| load_detect_two_trip || input_phase_loss_trip
		|| output_phase_loss_trip;
	assign running = run_cmd_fwd || run_cmd_rev;
	assign fault_evt = (state_q == FAR_IDLE) && output_shutoff && running;

	far_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.restart(fault_evt),
		.tick(tick)
	);

	// ==========================================================
	// sequence
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= FAR_IDLE;
		end else begin
			unique case (state_q)
				FAR_IDLE: begin
					if (fault_evt) begin
						if (restartable && !other_fault_trip && count_q < limit_q) begin
							state_q <= FAR_WITHDRAW;
						end else begin
							state_q <= FAR_LOCKOUT;
						end
					end
				end
				FAR_WITHDRAW: state_q <= FAR_DIAG;
				FAR_DIAG: begin
					if (diag_done) begin
						state_q <= diag_pass ? FAR_WAIT_INT : FAR_LOCKOUT;
					end
				end
				FAR_WAIT_INT: begin
					if (int_cnt_q == 13'h0000) begin
						state_q <= FAR_RESTART;
					end
				end
				FAR_RESTART: state_q <= FAR_IDLE;
				FAR_LOCKOUT: begin
					if (manual_fault_reset) begin
						state_q <= FAR_IDLE;
					end
				end
				default: state_q <= FAR_IDLE;
			endcase
		end
	end

	// interval counter from shut-off
	always_ff @(posedge clk) begin
		if (rst) begin
			int_cnt_q <= 13'h0000;
		end else if (fault_evt) begin
			int_cnt_q <= interval_q;
		end else if (tick && int_cnt_q != 13'h0000) begin
			int_cnt_q <= int_cnt_q - 13'h0001;
		end
	end

	// attempt counter
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= 4'h0;
		end else if (manual_fault_reset) begin
			count_q <= 4'h0;
		end else if (good_arm_q && good_cnt_q == FAR_GOOD_RUN_TICKS) begin
			count_q <= 4'h0;
		end else if (state_q == FAR_RESTART) begin
			count_q <= count_q + 4'h1;
		end
	end

	// fault-free run timer after a restart
	always_ff @(posedge clk) begin
		if (rst || manual_fault_reset || (state_q != FAR_IDLE && state_q != FAR_RESTART)) begin
			good_arm_q <= 1'b0;
			good_cnt_q <= 13'h0000;
		end else if (state_q == FAR_RESTART) begin
			good_arm_q <= 1'b1;
			good_cnt_q <= 13'h0000;
		end else if (good_arm_q) begin
			if (good_cnt_q == FAR_GOOD_RUN_TICKS) begin
				good_arm_q <= 1'b0;
			end else if (tick) begin
				good_cnt_q <= good_cnt_q + 13'h0001;
			end
		end
	end

	// ==========================================================
	// drive-side outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			run_fwd_out <= 1'b0;
			run_rev_out <= 1'b0;
			diag_req <= 1'b0;
			fault_clear_req <= 1'b0;
			speed_search_req <= 1'b0;
			restart_stopped <= 1'b0;
		end else begin
			run_fwd_out <= run_cmd_fwd && state_q == FAR_IDLE && !fault_evt;
			run_rev_out <= run_cmd_rev && state_q == FAR_IDLE && !fault_evt;
			diag_req <= state_q == FAR_WITHDRAW;
			fault_clear_req <= state_q == FAR_DIAG && diag_done && diag_pass;
			speed_search_req <= state_q == FAR_RESTART;
			restart_stopped <= state_q == FAR_LOCKOUT && !manual_fault_reset;
		end
	end

	// multi-function output terminals
	for (genvar g = 0; g < FAR_NUM_MO; g++) begin : g_mo
		always_ff @(posedge clk) begin
			if (rst) begin
				mo_q[g] <= 1'b0;
			end else if (mofunc_q[g*FAR_MO_W +: FAR_MO_W] == FAR_MO_RESTART) begin
				mo_q[g] <= state_q != FAR_IDLE && state_q != FAR_LOCKOUT;
			end else if (mofunc_q[g*FAR_MO_W +: FAR_MO_W] == FAR_MO_FAULT) begin
				mo_q[g] <= state_q == FAR_LOCKOUT
					|| (state_q != FAR_IDLE && fosel_q);
			end else begin
				mo_q[g] <= 1'b0;
			end
		end
	end

	assign multi_out_0 = mo_q[0];
	assign multi_out_1 = mo_q[1];
	assign multi_out_2 = mo_q[2];
	assign multi_out_3 = mo_q[3];

	// ==========================================================
	// interrupts, read of status clears, set wins
	assign irq_evt[FAR_IRQ_ATTEMPT] = state_q == FAR_RESTART;
	assign irq_evt[FAR_IRQ_LOCKOUT] = state_q != FAR_LOCKOUT
		&& ((fault_evt && !(restartable && !other_fault_trip && count_q < limit_q))
		|| (state_q == FAR_DIAG && diag_done && !diag_pass));
	assign irq_evt[FAR_IRQ_GOODRUN] = good_arm_q && good_cnt_q == FAR_GOOD_RUN_TICKS
		&& !manual_fault_reset;

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else if (rd && wb_adr_i == FAR_REG_IRQ_STAT) begin
			irq_stat_q <= irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

/* File: verification/far_drive_model.sv */
// protection and run-sequence side model for the restart sequencer
`timescale 1ns/1ps
`default_nettype none
module far_drive_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [3:0] sel,
	input wire logic ok,
	input wire logic [1:0] dly,
	input wire logic diag_req,
	input wire logic fault_clear_req,
	input wire logic manual_fault_reset,
	output logic [13:0] trips,
	output logic other_fault_trip,
	output logic output_shutoff,
	output logic diag_done,
	output logic diag_pass
);
	logic [1:0] cnt_q;
	logic busy_q;
	// ==========================================================
	// trip and shut-off, cleared by fault clear or operator reset
	always_ff @(posedge clk) begin
		if (rst || fault_clear_req || manual_fault_reset) begin
			trips <= '0;
			other_fault_trip <= 1'b0;
			output_shutoff <= 1'b0;
		end else if (go) begin
			trips <= (sel < 4'he) ? (14'h1 << sel) : 14'h0;
			other_fault_trip <= (sel == 4'he);
			output_shutoff <= 1'b1;
		end
	end
	// ==========================================================
	// self-diagnosis answer, pass line toggles outside the answer
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			diag_done <= 1'b0;
			diag_pass <= 1'b0;
		end else begin
			diag_done <= 1'b0;
			diag_pass <= ~diag_pass;
			if (diag_req) begin
				busy_q <= 1'b1;
				cnt_q <= dly;
			end else if (busy_q && cnt_q == 2'h0) begin
				busy_q <= 1'b0;
				diag_done <= 1'b1;
				diag_pass <= ok;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/far_sequencer_asserts.sv */
// concurrent checks on the restart sequencer ports
`timescale 1ns/1ps
`default_nettype none
module far_sequencer_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic run_fwd_out,
	input wire logic run_rev_out,
	input wire logic diag_req,
	input wire logic diag_done,
	input wire logic diag_pass,
	input wire logic fault_clear_req,
	input wire logic speed_search_req,
	input wire logic restart_stopped,
	input wire logic manual_fault_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// bus and sequence checks
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_withdraw_diag: assert property (diag_req |-> !run_fwd_out && !run_rev_out)
		else $error("run command kept during diagnosis");
	chk_diag_after_run: assert property ($rose(diag_req) |-> $past(!run_fwd_out && !run_rev_out))
		else $error("diagnosis before run withdrawn");
	chk_clear_after_pass: assert property (fault_clear_req |-> $past(diag_done && diag_pass))
		else $error("fault clear without passed diagnosis");
	chk_interval_gap: assert property (fault_clear_req |=> !speed_search_req [*8])
		else $error("restart before interval");
	chk_no_search_locked: assert property (restart_stopped |-> !speed_search_req && !diag_req)
		else $error("attempt while stopped");
	chk_lock_holds: assert property (restart_stopped && !manual_fault_reset |=> restart_stopped)
		else $error("stop released without reset");
	chk_manual_unlock: assert property (manual_fault_reset |=> !restart_stopped)
		else $error("stop kept after manual reset");
	chk_req_pulse: assert property (diag_req || speed_search_req |=> !diag_req && !speed_search_req)
		else $error("request longer than one cycle");
	cov_search: cover property (speed_search_req);
	cov_lock: cover property ($rose(restart_stopped));
	cov_clear: cover property (fault_clear_req);
endmodule
bind far_sequencer far_sequencer_asserts i_far_sequencer_asserts (.clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .run_fwd_out, .run_rev_out, .diag_req, .diag_done, .diag_pass,
	.fault_clear_req, .speed_search_req, .restart_stopped, .manual_fault_reset);
`default_nettype wire

/* File: verification/far_sequencer_tb_top.sv */
// self-checking bench for the restart sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin for (int k = 0; k < 3000 && !(c); k++) @(posedge clk); \
	if (!(c)) begin err_count++; tally_and_finish(); end end
module far_sequencer_tb_top;
	import far_pkg::*;
	localparam int TC = 4;
	localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
	localparam logic [31:0] RV [7] = '{32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0, ok = 0, mrst = 0, fwd = 0, rev = 0;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic [3:0] sel = '0, mo, wsel = '0;
	logic [1:0] dly = '0;
	logic [13:0] trips;
	logic ack, oth, shut, dd, dp, rf, rr, dq, fc, ss, stop, irq, fs = 0;
	int err_count = 0, n_tests = 0, seed = 32'h8447, t0 = 0, cyc_n = 0;
	initial forever #5 clk = ~clk;
	always @(posedge clk) cyc_n++;
	far_sequencer #(.TICK_CYCLES(TC)) i_far_sequencer (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(wsel), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ground_fault_trip(trips[0]), .overvoltage_accel_trip(trips[1]),
		.overvoltage_decel_trip(trips[2]), .overvoltage_const_trip(trips[3]),
		.overcurrent_accel_trip(trips[4]), .overcurrent_decel_trip(trips[5]),
		.overcurrent_const_trip(trips[6]), .heatsink_overheat_trip(trips[7]),
		.motor_overload_trip(trips[8]), .drive_overload_trip(trips[9]),
		.load_detect_one_trip(trips[10]), .load_detect_two_trip(trips[11]),
		.input_phase_loss_trip(trips[12]), .output_phase_loss_trip(trips[13]),
		.other_fault_trip(oth), .output_shutoff(shut), .run_cmd_fwd(fwd), .run_cmd_rev(rev),
		.diag_done(dd), .diag_pass(dp), .manual_fault_reset(mrst), .run_fwd_out(rf),
		.run_rev_out(rr), .diag_req(dq), .fault_clear_req(fc), .speed_search_req(ss),
		.restart_stopped(stop), .multi_out_0(mo[0]), .multi_out_1(mo[1]), .multi_out_2(mo[2]),
		.multi_out_3(mo[3]), .irq);
	far_drive_model i_far_drive_model (.clk, .rst, .go, .sel, .ok, .dly, .diag_req(dq),
		.fault_clear_req(fc), .manual_fault_reset(mrst), .trips, .other_fault_trip(oth),
		.output_shutoff(shut), .diag_done(dd), .diag_pass(dp));
	// ==========================================================
	// expectations and drivers
	function automatic logic [3:0] exp_mo(input logic seq, input logic lock, input logic f);
		return {2{lock | (seq & f), seq}};
	endfunction
	function automatic logic [3:0] rnd_sel();
		return 4'($unsigned($random(seed)) % 14);
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		wsel <= 4'hf;
		@(posedge clk);
		`WAITC(ack === 1'b1)
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic fault(input logic [3:0] s, input logic p);
		@(posedge clk);
		go <= 1'b1;
		sel <= s;
		ok <= p;
		dly <= 2'($random(seed));
		t0 = cyc_n;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic mreset();
		@(posedge clk);
		mrst <= 1'b1;
		@(posedge clk);
		mrst <= 1'b0;
	endtask
	task automatic attempt(input logic [3:0] s);
		fault(s, 1'b1);
		`WAITC(fc === 1'b1)
		`CHK(mo, exp_mo(1'b1, 1'b0, fs))
		`WAITC(ss === 1'b1)
		`CHK((cyc_n - t0) inside {[5 * TC : 6 * TC + 10]}, 1'b1)
		repeat (3) @(posedge clk);
		`CHK({rf, rr}, {fwd, rev})
	endtask
	task automatic lock_check(input logic [3:0] s, input logic p);
		fault(s, p);
		`WAITC(stop === 1'b1)
		`CHK(stop, 1'b1)
		`CHK(mo, exp_mo(1'b0, 1'b1, fs))
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (RA[i]) begin
			wb(1'b0, RA[i], 32'h0);
			`CHK(q, RV[i])
		end
		wb(1'b1, FAR_REG_CTRL, 32'hf);
		wb(1'b0, FAR_REG_CTRL, 32'h0);
		`CHK(q, 32'ha)
		wb(1'b1, FAR_REG_INTERVAL, 32'h1fff);
		wb(1'b0, FAR_REG_INTERVAL, 32'h0);
		`CHK(q, 32'h1770)
		wb(1'b1, FAR_REG_INTERVAL, 32'h1);
		wb(1'b0, FAR_REG_INTERVAL, 32'h0);
		`CHK(q, 32'h5)
		wb(1'b1, FAR_REG_MOFUNC, 32'h0b0e0b0e);
		wb(1'b1, FAR_REG_CTRL, 32'h0);
		fwd <= 1'b1;
		lock_check(rnd_sel(), 1'b1);
		mreset();
		for (int s = 0; s < 14; s++) begin
			fs = 1'($random(seed));
			fwd <= ~fs;
			rev <= fs;
			wb(1'b1, FAR_REG_CTRL, {23'h0, fs, 8'h0a});
			attempt(4'(s));
			wb(1'b0, FAR_REG_STATUS, 32'h0);
			`CHK(q[3:0], 4'h1)
			mreset();
			wb(1'b0, FAR_REG_STATUS, 32'h0);
			`CHK(q[3:0], 4'h0)
		end
		`CHK(irq, 1'b0)
		wb(1'b1, FAR_REG_IRQ_MASK, 32'h7);
		`CHK(irq, 1'b1)
		wb(1'b0, FAR_REG_IRQ_STAT, 32'h0);
		`CHK({irq, q[2:0]}, 4'h3)
		wb(1'b1, FAR_REG_CTRL, {23'h0, fs, 8'h02});
		attempt(rnd_sel());
		attempt(rnd_sel());
		lock_check(rnd_sel(), 1'b1);
		wb(1'b0, FAR_REG_STATUS, 32'h0);
		`CHK({q[16], q[3:0]}, 5'h12)
		wb(1'b0, FAR_REG_IRQ_STAT, 32'h0);
		`CHK(q[2:0], 3'h3)
		mreset();
		lock_check(4'he, 1'b1);
		mreset();
		lock_check(rnd_sel(), 1'b0);
		mreset();
		attempt(rnd_sel());
		wb(1'b0, FAR_REG_IRQ_STAT, 32'h0);
		repeat (6000 * TC + 200) @(posedge clk);
		wb(1'b0, FAR_REG_STATUS, 32'h0);
		`CHK(q[3:0], 4'h0)
		wb(1'b0, FAR_REG_IRQ_STAT, 32'h0);
		`CHK(q[2:0], 3'h4)
		attempt(rnd_sel());
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, FAR_REG_STATUS, 32'h0);
		`CHK(q[3:0], 4'h0)
		tally_and_finish();
	end
endmodule
`default_nettype wire
